// ==== common/sic_map.svh ====
`ifndef SIC_MAP_SVH
`define SIC_MAP_SVH

// register byte offsets on the wishbone slave
`define SIC_ADR_CTRL 8'h00
`define SIC_ADR_STATUS 8'h04
`define SIC_ADR_CURRENT 8'h08

// control register fields and reset value
`define SIC_CTRL_RES 2:0
`define SIC_RES_RST 3'h0
`define SIC_RES_MAX 3'h5

// indexer geometry
`define SIC_POS_HOME 7'h10
`define SIC_POS_LAST 7'h7f
`define SIC_FULL_STEP 7'h20
`define SIC_QUARTER_LEN 6'h20
`define SIC_CUR_HOME 8'h47

// timing: clock period and overcurrent qualification, both in ns
`define SIC_CLK_NS 25
`define SIC_OCP_NS 3000

`endif

// ==== common/sic_pkg.sv ====
package sic_pkg;

	// indexer position, one entry of the 128-entry table
	typedef logic [6:0] sic_pos_t;

	// power and reset condition of the core
	typedef enum logic [1:0] {SIC_PWR_OFF, SIC_PWR_SLEEP, SIC_PWR_HOLD, SIC_PWR_RUN} sic_pwr_e;

	// analog protection sense inputs
	typedef struct packed {
		logic [7:0] fet_limit; // per-transistor current limit active
		logic hot; // die over temperature
		logic supply_low; // motor supply under threshold
	} sic_guard_s;

	// bridge drive towards the power stage
	typedef struct packed {
		logic en; // both bridges enabled
		logic hiz; // outputs high impedance
		logic signed [7:0] cur_a; // winding a, percent of full scale
		logic signed [7:0] cur_b; // winding b, percent of full scale
	} sic_drive_s;

endpackage : sic_pkg

// ==== logic/sic_sine_lut.sv ====
`timescale 1ns/10ps
`include "sic_map.svh"

// one winding: signed sine of the indexer phase, in percent
module sic_sine_lut import sic_pkg::*; #(
	parameter sic_pos_t PHASE_OFS = 7'h00 // quarter turn gives the cosine
) (
	input wire sic_pos_t phase_i, // indexer position
	output logic signed [7:0] level_o // signed current percent
);

	// first quarter of the sine, entries 32 down to 0
	localparam logic [32:0][6:0] QUARTER = {
		7'h64, 7'h64, 7'h64, 7'h63, 7'h62, 7'h61, 7'h60, 7'h5e, 7'h5c, 7'h5a, 7'h58,
		7'h56, 7'h53, 7'h50, 7'h4d, 7'h4a, 7'h47, 7'h43, 7'h3f, 7'h3c, 7'h38, 7'h33,
		7'h2f, 7'h2b, 7'h26, 7'h22, 7'h1d, 7'h18, 7'h14, 7'h0f, 7'h0a, 7'h05, 7'h00};

	sic_pos_t angle; // phase after offset, wraps naturally
	logic [5:0] idx; // mirrored quarter index
	logic [6:0] mag; // magnitude from table

	// fold four quadrants onto one stored quarter to save table area
	always_comb begin
		angle = phase_i + PHASE_OFS;
		idx = angle[5] ? (`SIC_QUARTER_LEN - {1'b0, angle[4:0]}) : {1'b0, angle[4:0]};
		mag = QUARTER[idx];
		level_o = angle[6] ? (8'h00 - {1'b0, mag}) : {1'b0, mag};
	end

endmodule : sic_sine_lut

// ==== logic/sic_indexer.sv ====
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "sic_map.svh"

// Notes on behaviour
// - reset low homes indexer, bridges off
// - steps during reset never move indexer
// - enable low drives bridges, steps accepted
// - enable high: bridges off, hiz, steps ignored
// - sleep low stops bridges, pump, regulator, clocks
// - asleep, step, dir, reset and enable ignored until wake; low supply still homes logic
// - long current limit trips, fault low
// - overcurrent trip held until reset or supply
// - any transistor's limit counts alike
// - overheat disables, fault low, auto resume
// - low supply resets logic, resumes after
// - each step rise moves 32 >> res_eff entries; exactly one entry only at 1/32
// - direction level picks forward or backward
// - three select bits, full to 1/32
module sic_indexer import sic_pkg::*; (
	input wire logic clk_i, // 40 MHz core clock
	input wire logic rst_i, // synchronous reset, high
	input wire logic ce_i, // clock enable, low freezes all
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [7:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte lanes
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	input wire logic step_i, // step pulse from controller
	input wire logic dir_i, // direction, high counts up
	input wire logic chip_reset_low_i, // chip reset, low active
	input wire logic output_enable_low_i, // bridge enable, low active
	input wire logic sleep_request_low_i, // sleep request, low active
	input wire sic_guard_s guard_i, // protection sense
	output sic_drive_s drive_o, // bridge drive
	output logic charge_pump_en_o, // gate drive pump running
	output logic aux_regulator_output_en_o, // aux regulator on
	output logic fault_flag_low_o // fault, low active
);

	localparam logic [7:0] OCP_CYC = 8'((`SIC_OCP_NS + `SIC_CLK_NS - 1) / `SIC_CLK_NS);

	// input synchronisers
	logic step_s1_q, step_s1_d; // first stage, read only by second
	logic step_s2_q, step_s2_d; // stable step level
	logic step_s3_q, step_s3_d; // delayed copy for edge
	logic dir_s1_q, dir_s1_d; // first stage
	logic dir_s2_q, dir_s2_d; // stable direction
	logic step_rise; // one cycle per external rise

	// core state
	sic_pwr_e pwr_q, pwr_d; // power condition
	sic_pos_t pos_q, pos_d; // indexer position
	logic [7:0] ocp_cnt_q, ocp_cnt_d; // current limit persistence
	logic ocp_q, ocp_d; // latched overcurrent trip
	logic [2:0] res_q, res_d; // resolution select
	logic [2:0] res_eff; // select clamped to finest
	sic_pos_t stride; // entries per step
	logic accept; // step acted upon
	logic limit_any; // any transistor limited

	// outputs
	sic_drive_s drive_q, drive_d; // registered bridge drive
	logic pump_q, pump_d; // pump and regulator on
	logic fault_low_q, fault_low_d; // registered fault flag
	logic signed [7:0] cur_a, cur_b; // table output for pos_d

	// bus
	logic ack_q, ack_d; // one-cycle acknowledge
	logic [31:0] dat_q, dat_d; // registered read data

	// sine for b and cosine for a from one table module
	sic_sine_lut #(.PHASE_OFS(7'h00)) u_lut_b (
		.phase_i(pos_d),
		.level_o(cur_b)
	);
	sic_sine_lut #(.PHASE_OFS(`SIC_FULL_STEP)) u_lut_a (
		.phase_i(pos_d),
		.level_o(cur_a)
	);

	// two flops before edge detection; stage one feeds stage two only
	always_comb begin
		step_s1_d = step_i;
		step_s2_d = step_s1_q;
		step_s3_d = step_s2_q;
		dir_s1_d = dir_i;
		dir_s2_d = dir_s1_q;
		step_rise = step_s2_q & ~step_s3_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			step_s1_q <= 1'b0;
			step_s2_q <= 1'b0;
			step_s3_q <= 1'b0;
			dir_s1_q <= 1'b0;
			dir_s2_q <= 1'b0;
		end else if (ce_i) begin
			step_s1_q <= step_s1_d;
			step_s2_q <= step_s2_d;
			step_s3_q <= step_s3_d;
			dir_s1_q <= dir_s1_d;
			dir_s2_q <= dir_s2_d;
		end
	end

	// power condition: supply beats sleep, sleep beats chip reset
	always_comb begin
		if (guard_i.supply_low) begin
			pwr_d = SIC_PWR_OFF;
		end else if (!sleep_request_low_i) begin
			pwr_d = SIC_PWR_SLEEP;
		end else if (!chip_reset_low_i) begin
			pwr_d = SIC_PWR_HOLD;
		end else begin
			pwr_d = SIC_PWR_RUN;
		end
	end

	// indexer and overcurrent next state
	always_comb begin
		limit_any = |guard_i.fet_limit;
		res_eff = (res_q > `SIC_RES_MAX) ? `SIC_RES_MAX : res_q;
		stride = `SIC_FULL_STEP >> res_eff;
		// both ends of the cycle must be running, so a reset edge loses the step
		accept = step_rise & (pwr_q == SIC_PWR_RUN) & (pwr_d == SIC_PWR_RUN)
			& ~output_enable_low_i;
		pos_d = pos_q;
		ocp_cnt_d = ocp_cnt_q;
		ocp_d = ocp_q;
		unique case (pwr_d)
			SIC_PWR_OFF, SIC_PWR_HOLD: begin
				// logic reset: home entry, trip cleared
				pos_d = `SIC_POS_HOME;
				ocp_cnt_d = 8'h00;
				ocp_d = 1'b0;
			end
			SIC_PWR_SLEEP: begin
				// clocks halted: everything holds
				pos_d = pos_q;
			end
			SIC_PWR_RUN: begin
				if (accept) begin
					// seven-bit arithmetic wraps at the table ends
					pos_d = dir_s2_q ? pos_q + stride : pos_q - stride;
				end
				if (limit_any && !ocp_q) begin
					if (ocp_cnt_q == OCP_CYC) begin
						ocp_d = 1'b1;
						ocp_cnt_d = 8'h00;
					end else begin
						ocp_cnt_d = ocp_cnt_q + 8'h01;
					end
				end else begin
					// a single quiet cycle restarts the qualification
					ocp_cnt_d = 8'h00;
				end
			end
		endcase
	end

	// output drive next values
	always_comb begin
		drive_d.en = (pwr_d == SIC_PWR_RUN) & ~output_enable_low_i & ~ocp_d
			& ~guard_i.hot;
		drive_d.hiz = ~drive_d.en;
		drive_d.cur_a = cur_a;
		drive_d.cur_b = cur_b;
		pump_d = (pwr_d == SIC_PWR_RUN) | (pwr_d == SIC_PWR_HOLD);
		// thermal is not latched, so the flag clears as the die cools
		fault_low_d = ~(ocp_d | guard_i.hot);
	end

	// wishbone slave: ack one cycle after strobe, write on the ack edge
	always_comb begin
		ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
		res_d = res_q;
		if (wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0]
			&& wb_adr_i == `SIC_ADR_CTRL) begin
			res_d = wb_dat_i[`SIC_CTRL_RES];
		end
		unique case (wb_adr_i)
			`SIC_ADR_CTRL: dat_d = {29'h0, res_q};
			`SIC_ADR_STATUS: dat_d = {20'h0, drive_q.en, pwr_q == SIC_PWR_SLEEP,
				guard_i.supply_low, guard_i.hot, ocp_q, pos_q};
			`SIC_ADR_CURRENT: dat_d = {16'h0, drive_q.cur_b, drive_q.cur_a};
			default: dat_d = 32'h0; // unmapped reads zero
		endcase
	end

	// single register process for core, outputs and bus
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_q <= SIC_PWR_HOLD;
			pos_q <= `SIC_POS_HOME;
			ocp_cnt_q <= 8'h00;
			ocp_q <= 1'b0;
			res_q <= `SIC_RES_RST;
			drive_q <= '{en: 1'b0, hiz: 1'b1, cur_a: `SIC_CUR_HOME, cur_b: `SIC_CUR_HOME};
			pump_q <= 1'b0;
			fault_low_q <= 1'b1;
			ack_q <= 1'b0;
			dat_q <= 32'h0;
		end else if (ce_i) begin
			pwr_q <= pwr_d;
			pos_q <= pos_d;
			ocp_cnt_q <= ocp_cnt_d;
			ocp_q <= ocp_d;
			res_q <= res_d;
			drive_q <= drive_d;
			pump_q <= pump_d;
			fault_low_q <= fault_low_d;
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	assign drive_o = drive_q;
	assign charge_pump_en_o = pump_q;
	assign aux_regulator_output_en_o = pump_q;
	assign fault_flag_low_o = fault_low_q;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_reset_homes: assert property (
		ce_i && pwr_d == SIC_PWR_HOLD |=> pos_q == `SIC_POS_HOME && !drive_o.en)
		else $error("chip reset did not home indexer");

	a_reset_no_step: assert property (
		ce_i && step_rise && !chip_reset_low_i && sleep_request_low_i ##1 ce_i
		|=> pos_q == `SIC_POS_HOME)
		else $error("step moved indexer during chip reset");

	a_step_moves: assert property (
		ce_i && accept && dir_s2_q |=> pos_q == sic_pos_t'($past(pos_q) + $past(stride)))
		else $error("accepted forward step did not advance");

	a_disable_hiz: assert property (
		ce_i && output_enable_low_i && pwr_q == SIC_PWR_RUN && pwr_d == SIC_PWR_RUN
		|=> !drive_o.en && drive_o.hiz && pos_q == $past(pos_q))
		else $error("disabled device drove or stepped");

	a_sleep_off: assert property (
		ce_i && !sleep_request_low_i && !guard_i.supply_low
		|=> !charge_pump_en_o && !aux_regulator_output_en_o && !drive_o.en)
		else $error("sleep left pump, regulator or bridge on");

	a_sleep_holds: assert property (
		pwr_q == SIC_PWR_SLEEP && pwr_d == SIC_PWR_SLEEP |=> $stable(pos_q) && $stable(ocp_q))
		else $error("state changed while asleep");

	a_ocp_trip: assert property (
		ce_i && pwr_d == SIC_PWR_RUN && limit_any && ocp_cnt_q == OCP_CYC
		|=> ocp_q && !fault_flag_low_o && !drive_o.en)
		else $error("qualified overcurrent did not trip");

	a_ocp_latched: assert property (
		ce_i && ocp_q && pwr_d inside {SIC_PWR_RUN, SIC_PWR_SLEEP} |=> ocp_q)
		else $error("overcurrent trip released without reset");

	a_hot_fault: assert property (
		ce_i && guard_i.hot |=> !fault_flag_low_o && !drive_o.en)
		else $error("overtemperature not flagged");

	a_supply_reset: assert property (
		ce_i && guard_i.supply_low |=> pos_q == `SIC_POS_HOME && !ocp_q && !charge_pump_en_o)
		else $error("undervoltage did not reset logic");

	a_backward: assert property (
		ce_i && accept && !dir_s2_q |=> pos_q == sic_pos_t'($past(pos_q) - $past(stride)))
		else $error("backward step moved wrongly");

	a_table_point: assert property (
		pos_q == 7'h70 |-> drive_o.cur_a == 8'sh47 && drive_o.cur_b == -8'sh47)
		else $error("full-step point four currents wrong");

	a_wrap_up: assert property (
		ce_i && accept && dir_s2_q && pos_q == `SIC_POS_LAST && stride == 7'h01 |=> pos_q == 7'h00)
		else $error("indexer did not wrap forward");

	a_one_edge: assert property (
		ce_i && step_rise |=> !step_rise)
		else $error("step edge seen twice");

	c_step_fwd: cover property (ce_i && accept && dir_s2_q);
	c_step_back: cover property (ce_i && accept && !dir_s2_q);
	c_ocp: cover property (ce_i && !ocp_q ##1 ocp_q);
	c_sleep_wake: cover property (pwr_q == SIC_PWR_SLEEP ##1 pwr_q == SIC_PWR_RUN);

endmodule : sic_indexer

// ==== tb/sic_ctl_model.sv ====
`timescale 1ns/10ps

// motion controller at the far side: step, direction and pin levels
module sic_ctl_model (
	input wire logic clk_i, // core clock
	output logic step_o, // step pulse
	output logic dir_o, // direction level
	output logic reset_low_o, // chip reset, low active
	output logic enable_low_o, // bridge enable, low active
	output logic sleep_low_o // sleep request, low active
);
	// pins driven from time zero, never left floating
	initial begin
		step_o = 1'b0;
		dir_o = 1'b1;
		reset_low_o = 1'b0;
		enable_low_o = 1'b1;
		sleep_low_o = 1'b1;
	end

	// one step; hold sets prompt or slow pulse widths
	task automatic pulse(input logic d, input int hold);
		@(posedge clk_i);
		dir_o <= d;
		repeat (3) @(posedge clk_i); // dir settles before the rise
		step_o <= 1'b1;
		repeat (hold) @(posedge clk_i);
		step_o <= 1'b0;
		repeat (hold) @(posedge clk_i);
	endtask : pulse

	// release sleep, then let the device settle before any step
	task automatic wake();
		@(posedge clk_i);
		sleep_low_o <= 1'b1;
		repeat (40000) @(posedge clk_i); // about 1 ms at 40 MHz
	endtask : wake
endmodule : sic_ctl_model

// ==== tb/stepper_indexer_control_tb.sv ====
`timescale 1ns/10ps

// self-checking bench for the indexer core
module stepper_indexer_control_tb import sic_pkg::*;;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ce = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, q, wb_dat_o;
	logic wb_ack_o, step, dir, rl, el, sl, pump, aux, fault_low;
	sic_guard_s guard = '0;
	sic_drive_s drive;
	logic [15:0] rnd = 16'd6532; // lfsr state
	int err_count = 0, tests_run = 0, exp_pos = 16, res = 0;

	always #12.5 clk_i = ~clk_i; // 40 MHz

	sic_ctl_model ctl (.clk_i(clk_i), .step_o(step), .dir_o(dir), .reset_low_o(rl),
		.enable_low_o(el), .sleep_low_o(sl));

	sic_indexer uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .step_i(step), .dir_i(dir), .chip_reset_low_i(rl),
		.output_enable_low_i(el), .sleep_request_low_i(sl), .guard_i(guard), .drive_o(drive),
		.charge_pump_en_o(pump), .aux_regulator_output_en_o(aux), .fault_flag_low_o(fault_low));

	// next random value, taps of a 16-bit lfsr
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask : chk

	// classic single wishbone cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i); // ack only looked at on the rising edge
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	// one step through the model, with expected position update
	task automatic stp(input logic d, input int hold, input bit moves);
		ctl.pulse(d, hold);
		if (moves)
			exp_pos = (exp_pos + (d ? 1 : -1) * (32 >> (res > 5 ? 5 : res))) & 127;
	endtask : stp

	// read back position and compare with the model
	task automatic pos_chk();
		wb(1'b0, 8'h04, 32'h0);
		chk({25'h0, q[6:0]}, exp_pos[31:0]);
	endtask : pos_chk

	// verdict, the one exit of the run
	task automatic test_done();
		$display("tests_run=%0d err_count=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	// hang guard, well beyond the ~42k cycles of the sequence
	initial begin
		repeat (60000) @(posedge clk_i);
		err_count++;
		test_done();
	end

	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		// chip reset held: home, bridges off, steps ignored
		stp(1'b1, 2, 0);
		pos_chk();
		chk({31'h0, drive.en}, 32'h0);
		wb(1'b0, 8'h08, 32'h0);
		chk(q, 32'h00004747);
		ctl.reset_low_o <= 1'b1;
		ctl.enable_low_o <= 1'b0;
		// every resolution code, random direction and pulse width
		for (int r = 0; r < 8; r++) begin
			res = r;
			wb(1'b1, 8'h00, r);
			rnd = lfsr(rnd);
			stp(rnd[0], rnd[1] ? 2 : 5, 1);
			pos_chk();
		end
		wb(1'b0, 8'h0c, 32'h0);
		chk(q, 32'h0); // unmapped reads zero
		// finest resolution: forward across the top entry, then back
		while (exp_pos != 127) stp(1'b1, 2, 1);
		stp(1'b1, 2, 1);
		pos_chk();
		// position 112 is table entry 112, full-step point four
		while (exp_pos != 112) stp(1'b0, 2, 1);
		pos_chk();
		wb(1'b0, 8'h08, 32'h0);
		chk(q, 32'h0000b947);
		// enable high: high impedance, steps ignored
		ctl.enable_low_o <= 1'b1;
		stp(1'b1, 2, 0);
		chk({30'h0, drive.hiz, drive.en}, 32'h2);
		pos_chk();
		ctl.enable_low_o <= 1'b0;
		stp(1'b0, 2, 1);
		chk({31'h0, drive.en}, 32'h1);
		pos_chk();
		// overcurrent on one random transistor: 121 cycles qualify
		rnd = lfsr(rnd);
		@(posedge clk_i);
		guard.fet_limit[rnd[2:0]] <= 1'b1;
		repeat (110) @(posedge clk_i);
		chk({31'h0, fault_low}, 32'h1);
		repeat (20) @(posedge clk_i);
		chk({30'h0, fault_low, drive.en}, 32'h0);
		wb(1'b0, 8'h04, 32'h0);
		chk(q, 32'h80 | exp_pos[31:0]); // trip bit set, bridges off, position kept
		guard.fet_limit <= 8'h00;
		repeat (5) @(posedge clk_i);
		chk({31'h0, fault_low}, 32'h0);
		ctl.reset_low_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		ctl.reset_low_o <= 1'b1;
		exp_pos = 16;
		repeat (3) @(posedge clk_i);
		chk({30'h0, fault_low, drive.en}, 32'h3);
		res = 0;
		wb(1'b1, 8'h00, 32'h0);
		// thermal: off while hot, back without reset; clock enable low freezes first
		ce <= 1'b0;
		guard.hot <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk({30'h0, fault_low, drive.en}, 32'h3); // frozen, no response yet
		ce <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk({30'h0, fault_low, drive.en}, 32'h0);
		guard.hot <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk({30'h0, fault_low, drive.en}, 32'h3);
		// low supply: logic back to home
		stp(1'b1, 2, 1);
		guard.supply_low <= 1'b1;
		repeat (3) @(posedge clk_i);
		guard.supply_low <= 1'b0;
		exp_pos = 16;
		repeat (3) @(posedge clk_i);
		pos_chk();
		wb(1'b1, 8'h00, 32'h0);
		// sleep: everything off, inputs ignored until wake
		ctl.sleep_low_o <= 1'b0;
		stp(1'b1, 2, 0);
		chk({29'h0, pump, aux, drive.en}, 32'h0);
		ctl.sleep_low_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		pos_chk();
		ctl.wake();
		stp(1'b1, 2, 1);
		pos_chk();
		test_done();
	end
endmodule : stepper_indexer_control_tb
